// *** hw/oms_pkg.sv ***
// Constants and carrier types for the operating mode and sleep controller.
package oms_pkg;

  // APB geometry: 12-bit byte address, 32-bit data.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets, one aligned word each.
  localparam logic [11:0] OFF_SYS_CTRL = 12'h000;
  localparam logic [11:0] OFF_RST_CAUSE = 12'h004;
  localparam logic [11:0] OFF_CLK_SETUP = 12'h008;
  localparam logic [11:0] OFF_TRIM_LOW = 12'h00C;
  localparam logic [11:0] OFF_TRIM_HIGH = 12'h010;
  localparam logic [11:0] OFF_MODE_STAT = 12'h014;
  // The data RAM occupies words 0x800..0xFFC, one byte per word.
  localparam logic [11:0] OFF_RAM_BASE = 12'h800;
  localparam int RAM_DEPTH = 512;
  localparam int RAM_AW = 9;

  // System control register fields.
  localparam int CTRL_SLEEP_PERMIT = 7;
  localparam int CTRL_PCONF_EN = 6;
  localparam int CTRL_BUSERR_EN = 5;
  localparam int CTRL_WDOG_EN = 4;

  // Reset cause register fields.
  localparam int CAUSE_SLEEP_REQ = 7;
  localparam int CAUSE_BUSERR = 5;
  localparam int CAUSE_WDOG = 4;
  localparam int CAUSE_PORTA = 3;
  localparam int CAUSE_PAD = 2;
  localparam int CAUSE_PAD_SLEEP = 1;
  localparam int CAUSE_WAS_ASLEEP = 0;

  // Clock setup register fields.
  localparam int CLK_RC_EN = 0;
  localparam int CLK_XTAL_EN = 1;
  localparam int CLK_EXT_SEL = 2;
  localparam int CLK_RC_BIAS = 3;
  localparam int CLK_CPU_LO = 4;
  localparam int CLK_CPU_HI = 5;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] CLK_RESET = 8'h01;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [1:0] CPU_CLK_RESET = 2'h0;
  // Mask of the writable bits in the clock setup register.
  localparam logic [7:0] CLK_WMASK = 8'h3F;
  // Mask of the clear-on-read bits in the reset cause register.
  localparam logic [7:0] CAUSE_RC_MASK = 8'h3F;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Operating modes, also shown in the mode status register.
  typedef enum logic [1:0] {
    MODE_START,
    MODE_ACTIVE,
    MODE_STANDBY,
    MODE_SLEEP
  } oms_mode_type;

  // One APB request as the master drives it.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } oms_apb_req_type;

  // Synchronised or same-clock reset sources.
  typedef struct packed {
    logic pad;
    logic porta;
    logic wdog;
    logic buserr;
  } oms_src_type;

  // Reset lines distributed through the system.
  typedef struct packed {
    logic cold;
    logic system;
    logic pconf;
    logic sleep;
    logic cpu;
  } oms_resets_type;

endpackage : oms_pkg

// *** hw/oms_ram.sv ***
// Byte-wide data RAM with registered read and no reset of its contents.
module oms_ram (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [oms_pkg::RAM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // Storage array; contents are undefined after start-up by design.
  logic [7:0] mem_reg [oms_pkg::RAM_DEPTH];

  // Write port and registered read port; no reset so the array maps to RAM cells.
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (wr_en)
      begin
        mem_reg[addr] <= wdata;
      end
      rdata <= mem_reg[addr];
    end
  end

endmodule : oms_ram

// *** hw/oms_sleep_ctrl.sv ***
// Operating mode, reset distribution and sleep controller with APB registers.
// Functional notes
// - Power-on clears all, RC on, crystal off.
// - System reset clears system bits, keeps clocks; here the processor clock field of the clock setup register returns to 0.
// - HALT enters standby, CPU clock stops, peripheral clocks keep running.
// - Reset or enabled wake leaves standby.
// - Sleep stops all clocks and peripherals.
// - Sleep needs permit then request write.
// - Only POR, pin or port A wake.
// - Power-on wake loses RAM contents.
// - Port A wake keeps cold-reset bits.
// - Was-asleep flag set by any sleep.
// - Data RAM has no reset.
// - Collect reset sources, distribute resets.
// - Sleep permit bit 7, cold reset.
// - Sleep request bit 7, reads zero.
// - Sleep reset held throughout sleep.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
module oms_sleep_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_reset,
  input wire logic port_a_wake_reset,
  input wire logic watchdog_reset,
  input wire logic bus_error_reset,
  input wire logic halt_exec,
  input wire logic wake_request,
  output logic cold_reset,
  output logic system_wide_reset,
  output logic port_config_reset,
  output logic sleep_reset,
  output logic cpu_reset,
  output logic cpu_clock_en,
  output logic periph_clock_en,
  output logic rc_osc_en,
  output logic xtal_osc_en,
  output logic external_clock_select,
  output logic rc_bias_keep,
  output logic [1:0] processor_clock,
  output logic [7:0] rc_trim_low,
  output logic [7:0] rc_trim_high,
  output logic [1:0] op_mode
);

  // Bundled APB request, for the decode helpers below.
  oms_pkg::oms_apb_req_type req;
  // Pin synchronisers: three stages each, the first read only by the second.
  logic [2:0] pad_sync_reg;
  logic [2:0] porta_sync_reg;
  // Filtered pin levels, updated once stages two and three agree.
  logic pad_level_reg;
  logic porta_level_reg;
  // Current reset sources after enable gating.
  oms_pkg::oms_src_type src;
  // Registers seen by software.
  logic [7:0] system_control_register_reg;
  logic [7:0] reset_cause_register_reg;
  logic [7:0] clock_setup_register_reg;
  logic [7:0] rc_trim_low_reg;
  logic [7:0] rc_trim_high_reg;
  // Operating mode state.
  oms_pkg::oms_mode_type mode_reg;
  oms_pkg::oms_mode_type mode_next;
  // Distributed reset lines.
  oms_pkg::oms_resets_type resets_reg;
  // APB handshake and decoded strokes.
  logic pready_reg;
  logic access;
  logic wr_stb;
  logic rd_stb;
  logic mapped;
  logic ram_hit;
  logic [7:0] ram_rdata;
  // Any system reset source active this cycle.
  logic sys_src;
  // Software asks for sleep and is allowed to.
  logic sleep_go;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Tells whether an address falls in the data RAM window.
  function automatic logic is_ram(input logic [11:0] addr);
    is_ram = (addr >= oms_pkg::OFF_RAM_BASE) && (addr[1:0] == 2'b00);
  endfunction : is_ram

  // Tells whether an address selects one of the control words.
  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] off);
    is_reg = (addr == off);
  endfunction : is_reg

  // Access phase completes at the edge where pready is seen high.
  assign access = req.psel && req.penable;
  assign wr_stb = access && pready_reg && req.pwrite;
  assign rd_stb = access && pready_reg && !req.pwrite;
  assign ram_hit = is_ram(req.paddr);
  assign mapped = ram_hit || is_reg(req.paddr, oms_pkg::OFF_SYS_CTRL)
    || is_reg(req.paddr, oms_pkg::OFF_RST_CAUSE) || is_reg(req.paddr, oms_pkg::OFF_CLK_SETUP)
    || is_reg(req.paddr, oms_pkg::OFF_TRIM_LOW) || is_reg(req.paddr, oms_pkg::OFF_TRIM_HIGH)
    || is_reg(req.paddr, oms_pkg::OFF_MODE_STAT);

  assign sleep_go = wr_stb && is_reg(req.paddr, oms_pkg::OFF_RST_CAUSE)
    && req.pwdata[oms_pkg::CAUSE_SLEEP_REQ]
    && system_control_register_reg[oms_pkg::CTRL_SLEEP_PERMIT];

  // sleep honours only wake causes
  // Watchdog and bus error have no clock in sleep, so they are ignored there.
  always_comb
  begin
    src.pad = pad_level_reg;
    src.porta = porta_level_reg;
    src.wdog = watchdog_reset && system_control_register_reg[oms_pkg::CTRL_WDOG_EN]
      && (mode_reg != oms_pkg::MODE_SLEEP);
    src.buserr = bus_error_reset && system_control_register_reg[oms_pkg::CTRL_BUSERR_EN]
      && (mode_reg != oms_pkg::MODE_SLEEP);
    sys_src = src.pad || src.porta || src.wdog || src.buserr;
  end

  // high level resets
  // Both pins come from outside the clock domain and pass three flip-flops.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pad_sync_reg <= 3'h0;
      porta_sync_reg <= 3'h0;
      pad_level_reg <= 1'b0;
      porta_level_reg <= 1'b0;
    end
    else if (ce)
    begin
      pad_sync_reg <= {pad_sync_reg[1:0], pin_reset};
      porta_sync_reg <= {porta_sync_reg[1:0], port_a_wake_reset};
      // A change counts only when the second and third stages agree.
      if (pad_sync_reg[1] == pad_sync_reg[2])
      begin
        pad_level_reg <= pad_sync_reg[2];
      end
      if (porta_sync_reg[1] == porta_sync_reg[2])
      begin
        porta_level_reg <= porta_sync_reg[2];
      end
    end
  end

  // Mode transitions; a reset source always returns through the start state.
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      oms_pkg::MODE_START:
      begin
        if (!sys_src)
        begin
          mode_next = oms_pkg::MODE_ACTIVE;
        end
      end
      oms_pkg::MODE_ACTIVE:
      begin
        if (sys_src)
        begin
          mode_next = oms_pkg::MODE_START;
        end
        else if (sleep_go)
        begin
          mode_next = oms_pkg::MODE_SLEEP;
        end
        else if (halt_exec)
        begin
          mode_next = oms_pkg::MODE_STANDBY;
        end
      end
      oms_pkg::MODE_STANDBY:
      begin
        if (sys_src)
        begin
          mode_next = oms_pkg::MODE_START;
        end
        else if (wake_request)
        begin
          mode_next = oms_pkg::MODE_ACTIVE;
        end
      end
      oms_pkg::MODE_SLEEP:
      begin
        if (src.pad || src.porta)
        begin
          mode_next = oms_pkg::MODE_START;
        end
      end
      default:
      begin
        mode_next = oms_pkg::MODE_START;
      end
    endcase
  end

  // power-on restarts everything
  // Power-on is the asynchronous rst; nothing stored before it is trusted.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_reg <= oms_pkg::MODE_START;
    end
    else if (ce)
    begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      resets_reg <= '{cold: 1'b1, system: 1'b1, pconf: 1'b1, sleep: 1'b1, cpu: 1'b1};
    end
    else if (ce)
    begin
      resets_reg.cold <= 1'b0;
      resets_reg.system <= sys_src;
      resets_reg.pconf <= sys_src && system_control_register_reg[oms_pkg::CTRL_PCONF_EN];
      resets_reg.sleep <= (mode_next == oms_pkg::MODE_SLEEP);
      resets_reg.cpu <= sys_src || (mode_next == oms_pkg::MODE_START);
    end
  end

  // permit bit, cold reset
  // Watchdog enable is sticky: software may set it but never clear it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      system_control_register_reg <= oms_pkg::CTRL_RESET;
    end
    else if (ce && wr_stb && is_reg(req.paddr, oms_pkg::OFF_SYS_CTRL))
    begin
      system_control_register_reg[oms_pkg::CTRL_SLEEP_PERMIT] <=
        req.pwdata[oms_pkg::CTRL_SLEEP_PERMIT];
      system_control_register_reg[oms_pkg::CTRL_PCONF_EN] <= req.pwdata[oms_pkg::CTRL_PCONF_EN];
      system_control_register_reg[oms_pkg::CTRL_BUSERR_EN] <=
        req.pwdata[oms_pkg::CTRL_BUSERR_EN];
      system_control_register_reg[oms_pkg::CTRL_WDOG_EN] <=
        system_control_register_reg[oms_pkg::CTRL_WDOG_EN] || req.pwdata[oms_pkg::CTRL_WDOG_EN];
    end
  end

  // cause bits survive port A wake
  // Cause bits clear on read, but a new cause in the same cycle wins.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reset_cause_register_reg <= oms_pkg::CAUSE_RESET;
    end
    else if (ce)
    begin
      if (rd_stb && is_reg(req.paddr, oms_pkg::OFF_RST_CAUSE))
      begin
        reset_cause_register_reg <= reset_cause_register_reg & ~oms_pkg::CAUSE_RC_MASK;
      end
      if (src.buserr)
      begin
        reset_cause_register_reg[oms_pkg::CAUSE_BUSERR] <= 1'b1;
      end
      if (src.wdog)
      begin
        reset_cause_register_reg[oms_pkg::CAUSE_WDOG] <= 1'b1;
      end
      if (src.porta)
      begin
        reset_cause_register_reg[oms_pkg::CAUSE_PORTA] <= 1'b1;
      end
      if (src.pad)
      begin
        reset_cause_register_reg[oms_pkg::CAUSE_PAD] <= 1'b1;
      end
      if (src.pad && mode_reg == oms_pkg::MODE_SLEEP)
      begin
        reset_cause_register_reg[oms_pkg::CAUSE_PAD_SLEEP] <= 1'b1;
      end
      if (mode_reg == oms_pkg::MODE_SLEEP)
      begin
        reset_cause_register_reg[oms_pkg::CAUSE_WAS_ASLEEP] <= 1'b1;
      end
      reset_cause_register_reg[oms_pkg::CAUSE_SLEEP_REQ] <= 1'b0;
    end
  end

  // clock setup kept except processor clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clock_setup_register_reg <= oms_pkg::CLK_RESET;
      rc_trim_low_reg <= oms_pkg::TRIM_RESET;
      rc_trim_high_reg <= oms_pkg::TRIM_RESET;
    end
    else if (ce)
    begin
      if (sys_src)
      begin
        clock_setup_register_reg[oms_pkg::CLK_CPU_HI:oms_pkg::CLK_CPU_LO] <=
          oms_pkg::CPU_CLK_RESET;
      end
      else if (wr_stb && is_reg(req.paddr, oms_pkg::OFF_CLK_SETUP))
      begin
        clock_setup_register_reg <= req.pwdata[7:0] & oms_pkg::CLK_WMASK;
      end
      if (wr_stb && is_reg(req.paddr, oms_pkg::OFF_TRIM_LOW))
      begin
        rc_trim_low_reg <= req.pwdata[7:0];
      end
      if (wr_stb && is_reg(req.paddr, oms_pkg::OFF_TRIM_HIGH))
      begin
        rc_trim_high_reg <= req.pwdata[7:0];
      end
    end
  end

  oms_ram u_ram (
    .clk(clk),
    .ce(ce),
    .wr_en(wr_stb && ram_hit),
    .addr(req.paddr[oms_pkg::RAM_AW+1:2]),
    .wdata(req.pwdata[7:0]),
    .rdata(ram_rdata)
  );

  // APB slave: one wait state, so read data and RAM output are ready with pready.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready_reg <= 1'b0;
      prdata <= oms_pkg::RDATA_ZERO;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready_reg <= access && !pready_reg;
      if (access && !pready_reg)
      begin
        pslverr <= !mapped;
        prdata <= oms_pkg::RDATA_ZERO;
        if (!req.pwrite)
        begin
          if (ram_hit)
          begin
            prdata <= {24'h00_0000, ram_rdata};
          end
          else if (is_reg(req.paddr, oms_pkg::OFF_SYS_CTRL))
          begin
            prdata <= {24'h00_0000, system_control_register_reg};
          end
          else if (is_reg(req.paddr, oms_pkg::OFF_RST_CAUSE))
          begin
            prdata <= {24'h00_0000, reset_cause_register_reg};
          end
          else if (is_reg(req.paddr, oms_pkg::OFF_CLK_SETUP))
          begin
            prdata <= {24'h00_0000, clock_setup_register_reg};
          end
          else if (is_reg(req.paddr, oms_pkg::OFF_TRIM_LOW))
          begin
            prdata <= {24'h00_0000, rc_trim_low_reg};
          end
          else if (is_reg(req.paddr, oms_pkg::OFF_TRIM_HIGH))
          begin
            prdata <= {24'h00_0000, rc_trim_high_reg};
          end
          else if (is_reg(req.paddr, oms_pkg::OFF_MODE_STAT))
          begin
            prdata <= {30'h0000_0000, mode_reg};
          end
        end
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // sleep gates every clock
  // Clock enables and oscillator controls come straight from flip-flops.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_clock_en <= 1'b0;
      periph_clock_en <= 1'b0;
      rc_osc_en <= 1'b1;
      xtal_osc_en <= 1'b0;
    end
    else if (ce)
    begin
      cpu_clock_en <= (mode_next == oms_pkg::MODE_ACTIVE);
      periph_clock_en <= (mode_next != oms_pkg::MODE_SLEEP);
      rc_osc_en <= clock_setup_register_reg[oms_pkg::CLK_RC_EN]
        && (mode_next != oms_pkg::MODE_SLEEP);
      xtal_osc_en <= clock_setup_register_reg[oms_pkg::CLK_XTAL_EN]
        && (mode_next != oms_pkg::MODE_SLEEP);
    end
  end

  // Register-backed outputs mirror their sources directly.
  assign pready = pready_reg;
  assign cold_reset = resets_reg.cold;
  assign system_wide_reset = resets_reg.system;
  assign port_config_reset = resets_reg.pconf;
  assign sleep_reset = resets_reg.sleep;
  assign cpu_reset = resets_reg.cpu;
  assign external_clock_select = clock_setup_register_reg[oms_pkg::CLK_EXT_SEL];
  assign rc_bias_keep = clock_setup_register_reg[oms_pkg::CLK_RC_BIAS];
  assign processor_clock = clock_setup_register_reg[oms_pkg::CLK_CPU_HI:oms_pkg::CLK_CPU_LO];
  assign rc_trim_low = rc_trim_low_reg;
  assign rc_trim_high = rc_trim_high_reg;
  assign op_mode = mode_reg;

endmodule : oms_sleep_ctrl

// *** verification/oms_core_model.sv ***
// Behavioural processor core driving APB, HALT, wake and the two reset lines.
module oms_core_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output oms_pkg::oms_apb_req_type req,
  output logic halt_exec,
  output logic wake_request,
  output logic pin_reset,
  output logic port_a_wake_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Everything idles low from time zero.
  initial
  begin
    req = '0;
    halt_exec = 1'b0;
    wake_request = 1'b0;
    pin_reset = 1'b0;
    port_a_wake_reset = 1'b0;
  end
  // One APB transfer, entered and left just after a rising edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // A spare edge keeps the next setup out of this time step.
    @(posedge clk);
  endtask : xfer
  task automatic sleep_enter(input logic [7:0] clk_cfg);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, oms_pkg::OFF_CLK_SETUP, 32'(clk_cfg & 8'hF7), rd, err);
    xfer(1'b1, oms_pkg::OFF_SYS_CTRL, 32'h0000_0080, rd, err);
    xfer(1'b1, oms_pkg::OFF_RST_CAUSE, 32'h0000_0080, rd, err);
    // idle slot after the sleep write
    @(posedge clk);
  endtask : sleep_enter
  // One-cycle HALT (halt=1) or enabled wake request (halt=0).
  task automatic pulse(input logic halt);
    halt_exec <= halt;
    wake_request <= !halt;
    @(posedge clk);
    halt_exec <= 1'b0;
    wake_request <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic wake_line(input logic porta, input int cycles);
    port_a_wake_reset <= porta;
    pin_reset <= !porta;
    repeat (cycles) @(posedge clk);
    port_a_wake_reset <= 1'b0;
    pin_reset <= 1'b0;
  endtask : wake_line
endmodule : oms_core_model

// *** verification/oms_sleep_ctrl_sva.sv ***
// Concurrent checks on the mode, clock and reset outputs of the sleep controller.
module oms_sleep_ctrl_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_reset,
  input wire logic port_a_wake_reset,
  input wire logic halt_exec,
  input wire logic wake_request,
  input wire logic cold_reset,
  input wire logic system_wide_reset,
  input wire logic port_config_reset,
  input wire logic sleep_reset,
  input wire logic cpu_reset,
  input wire logic cpu_clock_en,
  input wire logic periph_clock_en,
  input wire logic rc_osc_en,
  input wire logic xtal_osc_en,
  input wire logic [1:0] op_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Wake lines quiet; synchronisers drained.
  sequence s_lines_quiet;
    (!pin_reset && !port_a_wake_reset)[*6];
  endsequence
  // Start mode with system and processor resets.
  sequence s_reset_entry;
    op_mode == oms_pkg::MODE_START && system_wide_reset && cpu_reset;
  endsequence
  a_cold_single_pulse: assert property (!rst && cold_reset |=> !cold_reset)
    else $error("cold reset stayed high past one cycle");
  a_por_osc_state: assert property (cold_reset |-> rc_osc_en && !xtal_osc_en)
    else $error("oscillators wrong during cold reset");
  a_pconf_inside: assert property (port_config_reset |-> system_wide_reset)
    else $error("port reset without system reset");
  a_halt_standby: assert property (s_lines_quiet ##0 (op_mode == oms_pkg::MODE_ACTIVE
    && halt_exec && !wake_request) |=> op_mode == oms_pkg::MODE_STANDBY)
    else $error("halt did not enter standby");
  a_standby_clocks: assert property (op_mode == oms_pkg::MODE_STANDBY
    |-> !cpu_clock_en && periph_clock_en)
    else $error("standby clock gating wrong");
  a_standby_wake: assert property (op_mode == oms_pkg::MODE_STANDBY && wake_request
    |=> op_mode == oms_pkg::MODE_ACTIVE)
    else $error("wake request did not leave standby");
  a_sleep_clocks_off: assert property (op_mode == oms_pkg::MODE_SLEEP
    |-> !cpu_clock_en && !periph_clock_en)
    else $error("clock running in sleep");
  a_sleep_stays: assert property (s_lines_quiet ##0 op_mode == oms_pkg::MODE_SLEEP
    |=> op_mode == oms_pkg::MODE_SLEEP)
    else $error("sleep left without a wake cause");
  a_line_wakes: assert property (op_mode == oms_pkg::MODE_SLEEP
    && $rose(pin_reset || port_a_wake_reset) |-> ##[1:8] s_reset_entry)
    else $error("wake line did not restart the core");
  a_sleep_reset_held: assert property (op_mode == oms_pkg::MODE_SLEEP |-> sleep_reset)
    else $error("sleep reset low while asleep");
endmodule : oms_sleep_ctrl_sva

bind oms_sleep_ctrl oms_sleep_ctrl_sva chk_u (
  .clk(clk), .rst(rst), .pin_reset(pin_reset), .port_a_wake_reset(port_a_wake_reset),
  .halt_exec(halt_exec), .wake_request(wake_request), .cold_reset(cold_reset),
  .system_wide_reset(system_wide_reset), .port_config_reset(port_config_reset),
  .sleep_reset(sleep_reset), .cpu_reset(cpu_reset), .cpu_clock_en(cpu_clock_en),
  .periph_clock_en(periph_clock_en), .rc_osc_en(rc_osc_en), .xtal_osc_en(xtal_osc_en),
  .op_mode(op_mode)
);

// *** verification/operating_mode_sleep_control_bench.sv ***
// Self-checking bench for the operating mode and sleep controller.
module operating_mode_sleep_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, watchdog_reset, bus_error_reset, pready, pslverr, err;
  logic halt_exec, wake_request, pin_reset, port_a_wake_reset, cold_reset;
  logic system_wide_reset, port_config_reset, sleep_reset, cpu_reset, cpu_clock_en;
  logic periph_clock_en, rc_osc_en, xtal_osc_en, external_clock_select, rc_bias_keep;
  logic [1:0] processor_clock, op_mode;
  logic [7:0] rc_trim_low, rc_trim_high;
  logic [31:0] prdata, rd;
  oms_pkg::oms_apb_req_type req;
  // Shadow model of the configuration registers.
  int m_clk, seed = 83, miscompares = 0, cmp_count = 0, cycles = 0;
  int addr_q[$], val_q[$];
  oms_core_model core_u (
    .clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .req(req),
    .halt_exec(halt_exec), .wake_request(wake_request), .pin_reset(pin_reset),
    .port_a_wake_reset(port_a_wake_reset)
  );
  oms_sleep_ctrl dut_u (
    .clk(clk), .rst(rst), .ce(ce), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_reset(pin_reset),
    .port_a_wake_reset(port_a_wake_reset), .watchdog_reset(watchdog_reset),
    .bus_error_reset(bus_error_reset), .halt_exec(halt_exec), .wake_request(wake_request),
    .cold_reset(cold_reset), .system_wide_reset(system_wide_reset),
    .port_config_reset(port_config_reset), .sleep_reset(sleep_reset), .cpu_reset(cpu_reset),
    .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en), .rc_osc_en(rc_osc_en),
    .xtal_osc_en(xtal_osc_en), .external_clock_select(external_clock_select),
    .rc_bias_keep(rc_bias_keep), .processor_clock(processor_clock),
    .rc_trim_low(rc_trim_low), .rc_trim_high(rc_trim_high), .op_mode(op_mode)
  );
  // Clock at 250 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, far above the run's length.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // Compares one register read word.
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word
  // Compares a group of output pins.
  task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_port
  // Reads a register; checks data and error.
  task automatic rd_chk(input logic [11:0] a, input int exp, input logic exp_err);
    core_u.xfer(1'b0, a, 32'h0000_0000, rd, err);
    cmp_word(rd, 32'(exp), "read data");
    cmp_word({31'h0, err}, {31'h0, exp_err}, "slave error");
  endtask : rd_chk
  task automatic wr(input logic [11:0] a, input int v);
    core_u.xfer(1'b1, a, 32'(v), rd, err);
  endtask : wr
  // Waits until the core runs again.
  task automatic wait_active();
    while (op_mode !== 2'b01) @(posedge clk);
  endtask : wait_active
  // Checks clock setup and trims.
  task automatic chk_cfg();
    for (int i = 0; i < 3; i++) rd_chk(12'(addr_q[i]), val_q[i], 1'b0);
  endtask : chk_cfg
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    watchdog_reset = 1'b0;
    bus_error_reset = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(oms_pkg::OFF_SYS_CTRL, 0, 1'b0);
    rd_chk(oms_pkg::OFF_RST_CAUSE, 0, 1'b0);
    addr_q = '{oms_pkg::OFF_CLK_SETUP, oms_pkg::OFF_TRIM_LOW, oms_pkg::OFF_TRIM_HIGH};
    val_q = '{1, 0, 0};
    chk_cfg();
    cmp_port({4'h0, rc_osc_en, xtal_osc_en, op_mode}, 8'h09, "osc and mode");
    // Unmapped place refuses and reads zero.
    wr(12'h018, 255);
    rd_chk(12'h018, 0, 1'b1);
    // Random clock setup (RC kept on) and trims.
    m_clk = ($random(seed) & 32'h0000_003F) | 1;
    val_q = '{m_clk, $random(seed) & 32'h0000_00FF, $random(seed) & 32'h0000_00FF};
    for (int i = 0; i < 3; i++) wr(12'(addr_q[i]), val_q[i]);
    chk_cfg();
    cmp_port({6'h0, processor_clock}, 8'(m_clk >> 4), "processor clock");
    cmp_port(rc_trim_high, 8'(val_q[2]), "trim pins");
    // Request without permit stays active and reads zero.
    wr(oms_pkg::OFF_RST_CAUSE, 32'h0000_0080);
    cmp_port({6'h0, op_mode}, 8'h01, "mode after bare request");
    rd_chk(oms_pkg::OFF_RST_CAUSE, 0, 1'b0);
    // Standby by HALT, left by wake request.
    core_u.pulse(1'b1);
    cmp_port({5'h0, cpu_clock_en, op_mode}, 8'h02, "standby");
    core_u.pulse(1'b0);
    cmp_port({5'h0, cpu_clock_en, op_mode}, 8'h05, "standby left");
    // Two wakes from sleep: port A first, then the reset pin.
    for (int w = 0; w < 2; w++)
    begin
      core_u.sleep_enter(8'(m_clk));
      m_clk = m_clk & 32'h0000_0037;
      cmp_port({3'h0, sleep_reset, cpu_clock_en, periph_clock_en, op_mode}, 8'h13,
        "sleep entered");
      core_u.pulse(1'b1);
      core_u.pulse(1'b0);
      cmp_port({5'h0, sleep_reset, op_mode}, 8'h07, "still asleep");
      core_u.wake_line(w == 0, 10);
      wait_active();
      if (w == 0)
      begin
        m_clk = m_clk & 32'h0000_000F;
        val_q[0] = m_clk;
        chk_cfg();
        rd_chk(oms_pkg::OFF_SYS_CTRL, 32'h0000_0080, 1'b0);
        rd_chk(oms_pkg::OFF_RST_CAUSE, 32'h0000_0009, 1'b0);
        rd_chk(oms_pkg::OFF_RST_CAUSE, 0, 1'b0);
      end
      else
      begin
        core_u.xfer(1'b0, oms_pkg::OFF_RST_CAUSE, 32'h0000_0000, rd, err);
        cmp_word(rd & 32'h0000_0003, 32'h0000_0003, "pin wake cause");
      end
    end
    // Enabled watchdog, then a mid-run power-on reset.
    wr(oms_pkg::OFF_SYS_CTRL, 32'h0000_0010);
    watchdog_reset <= 1'b1;
    @(posedge clk);
    watchdog_reset <= 1'b0;
    rd_chk(oms_pkg::OFF_RST_CAUSE, 32'h0000_0010, 1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    val_q = '{1, 0, 0};
    chk_cfg();
    rd_chk(oms_pkg::OFF_SYS_CTRL, 0, 1'b0);
    summarize();
  end
endmodule : operating_mode_sleep_control_bench
